// >>> logic/sol_pkg.sv
// package for the pwm shutdown output level block
package sol_pkg;
   localparam int          NUM_OUT          = 6;
   localparam int          ADDR_W           = 4;
   localparam logic [3:0]  LEVEL_ADDR       = 4'h0;
   localparam logic [3:0]  CTRL_ADDR        = 4'h1;
   localparam logic [3:0]  SRC_ADDR         = 4'h2;
   localparam logic [3:0]  STATUS_ADDR      = 4'h3;
   localparam logic [7:0]  LEVEL_RESET      = 8'h00;
   localparam logic [7:0]  LEVEL_MASK       = 8'h3F;
   localparam int          CTRL_EN_BIT      = 0;
   localparam int          CTRL_RESTART_BIT = 1;
   localparam int          STAT_EVENT_BIT   = 0;
   localparam int          STAT_IRQ_BIT     = 1;
   localparam int          NUM_SRC          = 5;
   // level bit positions for outputs A..F
   localparam int          LVL_A_BIT        = 0;
   localparam int          LVL_B_BIT        = 1;
   localparam int          LVL_C_BIT        = 2;
   localparam int          LVL_D_BIT        = 3;
   localparam int          LVL_E_BIT        = 4;
   localparam int          LVL_F_BIT        = 5;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
      logic              wr;
      logic              rd;
   } sol_bus_s;
endpackage

// >>> logic/sol_shutdown_level.sv
// shutdown level register and output forcing for six pwm outputs
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

module sol_shutdown_level
   import sol_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire sol_bus_s           bus,
   output logic [7:0]              rdata,
   input  wire logic [NUM_SRC-1:0] src_in,
   input  wire logic [NUM_OUT-1:0] pwm_in,
   output logic [NUM_OUT-1:0]      pwm_out,
   output logic                    shutdown_active
);
   logic [7:0]         level_q;
   logic [1:0]         ctrl_q;
   logic [NUM_SRC-1:0] sel_q;
   logic               event_q;
   logic               irq_q;
   logic [NUM_SRC-1:0] s1_q;
   logic [NUM_SRC-1:0] s2_q;
   logic [NUM_SRC-1:0] s3_q;
   logic [NUM_SRC-1:0] src_q;
   logic [NUM_SRC-1:0] src_d;
   logic               trip;
   logic               shut_d;
   logic [NUM_OUT-1:0] out_d;

   // three-stage sampling; a change counts once stages two and three agree
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         src_q <= '0;
      end
      else
      begin
         s1_q <= src_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         src_q <= src_d;
      end
   end

   // a source bit moves on only once stages two and three agree
   for (genvar g = 0; g < NUM_SRC; g++)
   begin : g_src
      assign src_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : src_q[g];
   end

   // trip needs the enable and one selected, filtered source
   assign trip = ctrl_q[CTRL_EN_BIT] && |(src_q & sel_q);

   // register writes; unmapped addresses are ignored

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         level_q <= LEVEL_RESET;
         ctrl_q  <= '0;
         sel_q   <= '0;
      end
      else if (bus.wr)
      begin
         if (bus.addr == LEVEL_ADDR)
            level_q <= bus.wdata & LEVEL_MASK;
         else if (bus.addr == CTRL_ADDR)
            ctrl_q <= bus.wdata[CTRL_RESTART_BIT:CTRL_EN_BIT];
         else if (bus.addr == SRC_ADDR)
            sel_q <= bus.wdata[NUM_SRC-1:0];
      end
   end

   // status: hardware set wins over software write-one-to-clear
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         event_q <= 1'b0;
         irq_q   <= 1'b0;
      end
      else
      begin
         if (trip)
            event_q <= 1'b1;
         else if (ctrl_q[CTRL_RESTART_BIT])
            event_q <= 1'b0;
         else if (bus.wr && bus.addr == STATUS_ADDR && bus.wdata[STAT_EVENT_BIT])
            event_q <= 1'b0;
         if (trip)
            irq_q <= 1'b1;
         else if (bus.wr && bus.addr == STATUS_ADDR && bus.wdata[STAT_IRQ_BIT])
            irq_q <= 1'b0;
      end
   end

   assign shut_d = trip || (event_q && !ctrl_q[CTRL_RESTART_BIT]);

   // per-output forcing: A..F take level bits 0..5
   for (genvar g = 0; g < NUM_OUT; g++)
   begin : g_force
      assign out_d[g] = shut_d ? level_q[g] : pwm_in[g];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pwm_out         <= '0;
         shutdown_active <= 1'b0;
      end
      else
      begin
         shutdown_active <= shut_d;
         pwm_out <= out_d;
      end
   end

   // read data stands one cycle after the strobe, zero otherwise
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         rdata <= '0;
      else if (bus.rd)
      begin
         if (bus.addr == LEVEL_ADDR)
            rdata <= level_q;
         else if (bus.addr == CTRL_ADDR)
            rdata <= 8'(ctrl_q);
         else if (bus.addr == SRC_ADDR)
            rdata <= 8'(sel_q);
         else if (bus.addr == STATUS_ADDR)
            rdata <= 8'({irq_q, event_q});
         else
            rdata <= '0;
      end
      else
         rdata <= '0;
   end

   // outputs follow the level register while forced
   a_level_force: assert property (@(posedge clk) disable iff (!rst_n)
      shut_d |=> pwm_out == level_q[NUM_OUT-1:0] || $past(bus.wr))
      else $error("shutdown output differs from level");
   a_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      (shut_d && !bus.wr) |=> pwm_out[LVL_A_BIT] == level_q[LVL_A_BIT])
      else $error("output a wrong in shutdown");
   a_out_bc: assert property (@(posedge clk) disable iff (!rst_n)
      (shut_d && !bus.wr) |=> pwm_out[LVL_C_BIT:LVL_B_BIT] == level_q[LVL_C_BIT:LVL_B_BIT])
      else $error("output b or c wrong in shutdown");
   a_out_d: assert property (@(posedge clk) disable iff (!rst_n)
      (shut_d && !bus.wr) |=> pwm_out[LVL_D_BIT] == level_q[LVL_D_BIT])
      else $error("output d wrong in shutdown");
   a_out_e: assert property (@(posedge clk) disable iff (!rst_n)
      (shut_d && !bus.wr) |=> pwm_out[LVL_E_BIT] == level_q[LVL_E_BIT])
      else $error("output e wrong in shutdown");
   a_out_f: assert property (@(posedge clk) disable iff (!rst_n)
      (shut_d && !bus.wr) |=> pwm_out[LVL_F_BIT] == level_q[LVL_F_BIT])
      else $error("output f wrong in shutdown");
   a_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (level_q & ~LEVEL_MASK) == '0)
      else $error("upper level bits not zero");
   a_reset_clear: assert property (@(posedge clk)
      !rst_n |=> level_q == LEVEL_RESET && pwm_out == '0 && !shutdown_active && rdata == '0)
      else $error("reset did not clear state");
   a_level_read: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr == LEVEL_ADDR) |=> rdata == $past(level_q))
      else $error("level read back wrong");
   a_ctrl_read: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr == CTRL_ADDR) |=> rdata == 8'($past(ctrl_q)))
      else $error("control read back wrong");
   a_sel_read: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr == SRC_ADDR) |=> rdata == 8'($past(sel_q)))
      else $error("source select read back wrong");
   a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr == STATUS_ADDR) |=> rdata == 8'({$past(irq_q), $past(event_q)}))
      else $error("status read back wrong");
   a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr > STATUS_ADDR) |=> rdata == '0)
      else $error("unmapped read not zero");
   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !bus.rd |=> rdata == '0)
      else $error("read data not idle");
   a_src_agree: assert property (@(posedge clk) disable iff (!rst_n)
      (s2_q == s3_q) |=> src_q == $past(s3_q))
      else $error("filtered source not taken");
   a_trip_flag: assert property (@(posedge clk) disable iff (!rst_n)
      trip |=> irq_q && event_q && shutdown_active)
      else $error("trip did not set flag");
   a_no_enable: assert property (@(posedge clk) disable iff (!rst_n)
      (!ctrl_q[CTRL_EN_BIT] && !event_q) |=> !shutdown_active)
      else $error("forced while disabled");
   a_irq_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (irq_q && !(bus.wr && bus.addr == STATUS_ADDR)) |=> irq_q)
      else $error("irq flag cleared without software");
   a_restart_go: assert property (@(posedge clk) disable iff (!rst_n)
      (!trip && ctrl_q[CTRL_RESTART_BIT]) |=> !shutdown_active)
      else $error("auto restart did not resume");
   a_restart_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (event_q && ctrl_q[CTRL_RESTART_BIT] && !trip) |=> !event_q)
      else $error("auto restart kept event status");
   a_manual_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (event_q && !ctrl_q[CTRL_RESTART_BIT] && !bus.wr) |=> event_q)
      else $error("status cleared without software");
   a_pass_thru: assert property (@(posedge clk) disable iff (!rst_n)
      !shut_d |=> pwm_out == $past(pwm_in))
      else $error("normal pwm not passed");

   // main scenarios
   c_trip: cover property (@(posedge clk) disable iff (!rst_n) trip);
   c_level_forced: cover property (@(posedge clk) disable iff (!rst_n)
      shutdown_active && bus.wr && bus.addr == LEVEL_ADDR);
   c_irq_clear: cover property (@(posedge clk) disable iff (!rst_n)
      irq_q ##1 !irq_q);
   c_restart: cover property (@(posedge clk) disable iff (!rst_n)
      shutdown_active ##1 !shutdown_active);
   c_manual: cover property (@(posedge clk) disable iff (!rst_n)
      event_q && !ctrl_q[CTRL_RESTART_BIT] ##1 !event_q);
endmodule

// >>> sim/pwm_shutdown_output_levels_bench.sv
// self-checking bench for the shutdown output level block
`timescale 1ns/100ps
module pwm_shutdown_output_levels_bench import sol_pkg::*;;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   sol_bus_s           bus = '0;
   logic [7:0]         rdata;
   logic [NUM_SRC-1:0] src_in = '0;
   logic [NUM_OUT-1:0] pwm_in = 6'h0F;
   logic [NUM_OUT-1:0] pwm_out;
   logic               shutdown_active;
   int                 n_fail = 0;
   int                 compares = 0;
   int                 cyc = 0;

   sol_shutdown_level DUT (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .src_in(src_in),
      .pwm_in(pwm_in), .pwm_out(pwm_out), .shutdown_active(shutdown_active));

   initial forever #10 clk = ~clk;

   task summarize;
      $display("comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // hang guard: the whole run needs well under a hundred cycles
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         n_fail++;
         summarize;
      end
   end

   task chk(string nm, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus <= '0;
   endtask

   task rd(logic [3:0] a, logic [7:0] exp, string nm);
      @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus <= '0;
      #1 chk(nm, exp, rdata);
   endtask

   // waits a bounded time for the forced state to reach exp
   task wt(logic exp);
      int i;
      i = 0;
      while (i < 12 && shutdown_active !== exp)
      begin
         @(posedge clk);
         #1 i++;
      end
      chk("shutdown_active", {7'h00, exp}, {7'h00, shutdown_active});
   endtask

   task t_regs;
      rd(LEVEL_ADDR, LEVEL_RESET, "level after reset");
      wr(LEVEL_ADDR, 8'hFF);
      rd(LEVEL_ADDR, 8'h3F, "level upper bits");
      rd(4'hF, 8'h00, "unmapped read");
      $display("t_regs done");
   endtask

   task t_force;
      wr(SRC_ADDR, 8'h01);
      wr(CTRL_ADDR, 8'h01);
      wr(LEVEL_ADDR, 8'h15);
      @(posedge clk) src_in <= 5'h01;
      wt(1'b1);
      chk("forced outputs", 8'h15, {2'b00, pwm_out});
      rd(STATUS_ADDR, 8'h03, "status after trip");
      wr(LEVEL_ADDR, 8'h2A);
      @(posedge clk);
      #1 chk("forced outputs", 8'h2A, {2'b00, pwm_out});
      $display("t_force done");
   endtask

   task t_restart;
      @(posedge clk) src_in <= 5'h00;
      repeat (8) @(posedge clk);
      #1 chk("held without restart", 8'h01, {7'h00, shutdown_active});
      wr(STATUS_ADDR, 8'h01);
      wt(1'b0);
      rd(STATUS_ADDR, 8'h02, "irq kept after event clear");
      wr(STATUS_ADDR, 8'h02);
      rd(STATUS_ADDR, 8'h00, "status cleared");
      @(posedge clk) pwm_in <= 6'h30;
      @(posedge clk);
      #1 chk("resumed outputs", 8'h30, {2'b00, pwm_out});
      wr(CTRL_ADDR, 8'h03);
      @(posedge clk) src_in <= 5'h01;
      wt(1'b1);
      @(posedge clk) src_in <= 5'h00;
      wt(1'b0);
      @(posedge clk) pwm_in <= 6'h0C;
      @(posedge clk);
      #1 chk("auto resumed outputs", 8'h0C, {2'b00, pwm_out});
      $display("t_restart done");
   endtask

   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_force;
      t_restart;
      summarize;
   end
endmodule
